//--- rtl/iof_cksum.sv
/*
 * Running frame checksum.
 * Assumes the caller clears it at each frame start.
 */
`timescale 1ns/10ps
module iof_cksum (
    input wire logic clk,           // system clock
    input wire logic rst_b,         // synchronous reset, active low
    input wire logic clear,         // start a new frame
    input wire logic add,           // add data_in this cycle
    input wire logic [7:0] data_in, // frame data byte
    output logic [7:0] cksum        // byte to send last
);

    typedef struct packed {
        logic [7:0] sum;
    } iof_cksum_state_t;

    iof_cksum_state_t q, d;

    // ------------------------------------------------------------
    // accumulate, carries dropped
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (clear) begin
            d.sum = 8'h00;
        end else if (add) begin
            d.sum = q.sum + data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // data sum plus this byte reads all ones
    assign cksum = iof_pkg::CKSUM_BASE - q.sum;

endmodule

//--- rtl/iof_frame_builder.sv
/*
 * I/O sample frame builder: one sample set in,
 * one framed byte stream out to the UART side.
 * Assumes the UART side takes a byte
 * on TX_VALID and TX_READY high at an edge,
 * samples arrive by valid/ready,
 * and register reads answer one cycle later.
 */
`timescale 1ns/10ps
module iof_frame_builder #(
    parameter int NUM_ANA = 4   // analog channels carried
) (
    input wire logic CLOCK,                          // 200 MHz system clock
    input wire logic RST_B,                          // synchronous reset, active low
    input wire logic SAMPLE_VALID,                   // sample set offered
    output logic SAMPLE_READY,                       // builder can take a sample set
    input wire logic SAMPLE_LONG,                    // sender uses 64-bit address
    input wire logic [63:0] SAMPLE_ADDR,             // sender address, short one in low 16 bits
    input wire logic [7:0] SAMPLE_RSSI,              // received power magnitude, -dBm
    input wire logic SAMPLE_ADDR_BCAST,              // packet was address broadcast
    input wire logic SAMPLE_PAN_BCAST,               // packet was PAN broadcast
    input wire logic [7:0] SAMPLE_COUNT,             // number of sample sets
    input wire logic [15:0] SAMPLE_MASK,             // channel enable mask
    input wire logic [15:0] SAMPLE_DIGITAL,          // digital line samples
    input wire logic [NUM_ANA*10-1:0] SAMPLE_ANALOG, // analog samples, channel 0 lowest
    output logic [7:0] TX_DATA,                      // frame byte to UART
    output logic TX_VALID,                           // TX_DATA holds a byte
    input wire logic TX_READY,                       // UART takes the byte
    input wire logic [7:0] REG_ADDR,                 // register byte address
    input wire logic [31:0] REG_WDATA,               // register write data
    input wire logic REG_WR,                         // write strobe
    input wire logic REG_RD,                         // read strobe
    output logic [31:0] REG_RDATA                    // read data, cycle after REG_RD
);

    typedef struct packed {
        iof_pkg::iof_state_t st;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic ready;
        logic enable;
        logic is_long;
        logic [63:0] addr;
        logic [7:0] rssi;
        logic [7:0] flags;
        logic [7:0] count;
        logic [15:0] mask;
        logic [15:0] dig;
        logic [NUM_ANA*10-1:0] ana;
        logic [2:0] addr_idx;
        logic [1:0] ana_ch;
        logic [15:0] frames;
        logic [15:0] drops;
        logic [31:0] rdata;
    } iof_top_state_t;

    iof_top_state_t q, d;

    logic [15:0] frame_len;
    logic [7:0] cksum;
    logic cks_clear;
    logic cks_add;
    logic advance;
    logic accept;
    logic [NUM_ANA-1:0] ana_en;
    logic dig_any;
    iof_pkg::iof_state_t nxt;
    logic [2:0] nxt_addr_idx;
    logic [1:0] nxt_ch;
    logic nxt_found;
    logic [1:0] first_ch;
    logic first_found;
    logic [7:0] nxt_byte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    iof_len u_len (
        .is_long(q.is_long),
        .mask(q.mask),
        .length(frame_len)
    );

    iof_cksum u_cksum (
        .clk(CLOCK),
        .rst_b(RST_B),
        .clear(cks_clear),
        .add(cks_add),
        .data_in(nxt_byte),
        .cksum(cksum)
    );

    // lowest enabled analog channel from a start index
    function automatic logic [2:0] find_ch(input logic [NUM_ANA-1:0] en, input int from);
        logic [2:0] res;
        res = 3'b000;
        for (int i = NUM_ANA - 1; i >= 0; i--) begin
            if (en[i] && i >= from) begin
                res = {1'b1, 2'(i)};
            end
        end
        return res;
    endfunction

    assign ana_en = q.mask[iof_pkg::ANA_LSB +: NUM_ANA];
    assign dig_any = |q.mask[iof_pkg::DIG_LSB +: iof_pkg::DIG_W];
    assign advance = q.tx_valid && TX_READY;
    assign accept = SAMPLE_VALID && q.ready;
    assign {first_found, first_ch} = find_ch(ana_en, 0);
    assign {nxt_found, nxt_ch} = find_ch(ana_en, int'(q.ana_ch) + 1);

    // ------------------------------------------------------------
    // sequencing of fields, one byte per handshake
    // ------------------------------------------------------------
    always_comb begin
        nxt = q.st;
        nxt_addr_idx = q.addr_idx;
        case (q.st)
            iof_pkg::ST_DELIM: begin
                nxt = iof_pkg::ST_LEN_HI;
            end
            iof_pkg::ST_LEN_HI: begin
                nxt = iof_pkg::ST_LEN_LO;
            end
            iof_pkg::ST_LEN_LO: begin
                nxt = iof_pkg::ST_TYPE;
            end
            iof_pkg::ST_TYPE: begin
                nxt = iof_pkg::ST_ADDR;
                nxt_addr_idx = q.is_long ? iof_pkg::ADDR_LONG_TOP : iof_pkg::ADDR_SHORT_TOP;
            end
            iof_pkg::ST_ADDR: begin
                // address walks from the most significant byte down
                if (q.addr_idx == 3'h0) begin
                    nxt = iof_pkg::ST_RSSI;
                end else begin
                    nxt_addr_idx = q.addr_idx - 3'h1;
                end
            end
            iof_pkg::ST_RSSI: begin
                nxt = iof_pkg::ST_FLAGS;
            end
            iof_pkg::ST_FLAGS: begin
                nxt = iof_pkg::ST_COUNT;
            end
            iof_pkg::ST_COUNT: begin
                nxt = iof_pkg::ST_MASK_HI;
            end
            iof_pkg::ST_MASK_HI: begin
                nxt = iof_pkg::ST_MASK_LO;
            end
            iof_pkg::ST_MASK_LO: begin
                if (dig_any) begin
                    nxt = iof_pkg::ST_DIG_HI;
                end else if (first_found) begin
                    nxt = iof_pkg::ST_ANA_HI;
                end else begin
                    nxt = iof_pkg::ST_CKSUM;
                end
            end
            iof_pkg::ST_DIG_HI: begin
                nxt = iof_pkg::ST_DIG_LO;
            end
            iof_pkg::ST_DIG_LO: begin
                nxt = first_found ? iof_pkg::ST_ANA_HI : iof_pkg::ST_CKSUM;
            end
            iof_pkg::ST_ANA_HI: begin
                nxt = iof_pkg::ST_ANA_LO;
            end
            iof_pkg::ST_ANA_LO: begin
                nxt = nxt_found ? iof_pkg::ST_ANA_HI : iof_pkg::ST_CKSUM;
            end
            iof_pkg::ST_CKSUM: begin
                nxt = iof_pkg::ST_IDLE;
            end
            default: begin
                nxt = iof_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // byte for the state being entered
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] ch;
        logic [15:0] ana_word;
        ch = (q.st == iof_pkg::ST_ANA_LO) ? nxt_ch : q.ana_ch;
        if (q.st == iof_pkg::ST_MASK_LO || q.st == iof_pkg::ST_DIG_LO) begin
            ch = first_ch;
        end
        // upper six bits of each analog field stay zero
        ana_word = {6'h00, q.ana[int'(ch) * iof_pkg::ANA_BITS +: iof_pkg::ANA_BITS]};
        nxt_byte = 8'h00;
        case (nxt)
            iof_pkg::ST_LEN_HI: begin
                nxt_byte = frame_len[15:8];
            end
            iof_pkg::ST_LEN_LO: begin
                nxt_byte = frame_len[7:0];
            end
            iof_pkg::ST_TYPE: begin
                nxt_byte = q.is_long ? iof_pkg::TYPE_LONG : iof_pkg::TYPE_SHORT;
            end
            iof_pkg::ST_ADDR: begin
                nxt_byte = q.addr[int'(nxt_addr_idx) * 8 +: 8];
            end
            iof_pkg::ST_RSSI: begin
                nxt_byte = q.rssi;
            end
            iof_pkg::ST_FLAGS: begin
                nxt_byte = q.flags;
            end
            iof_pkg::ST_COUNT: begin
                nxt_byte = q.count;
            end
            iof_pkg::ST_MASK_HI: begin
                nxt_byte = q.mask[15:8];
            end
            iof_pkg::ST_MASK_LO: begin
                nxt_byte = q.mask[7:0];
            end
            iof_pkg::ST_DIG_HI: begin
                nxt_byte = q.dig[15:8];
            end
            iof_pkg::ST_DIG_LO: begin
                nxt_byte = q.dig[7:0];
            end
            iof_pkg::ST_ANA_HI: begin
                nxt_byte = ana_word[15:8];
            end
            iof_pkg::ST_ANA_LO: begin
                nxt_byte = ana_word[7:0];
            end
            iof_pkg::ST_CKSUM: begin
                nxt_byte = cksum;
            end
            default: begin
                nxt_byte = 8'h00;
            end
        endcase
    end

    // checksum covers type through last analog byte only
    assign cks_clear = accept;
    assign cks_add = advance && (nxt != iof_pkg::ST_CKSUM) && (nxt != iof_pkg::ST_IDLE)
        && (nxt != iof_pkg::ST_LEN_HI) && (nxt != iof_pkg::ST_LEN_LO);

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.rdata = 32'h0000_0000;
        if (accept) begin
            // latch the set; inputs may change mid-frame
            d.is_long = SAMPLE_LONG;
            d.addr = SAMPLE_LONG ? SAMPLE_ADDR : {48'h0, SAMPLE_ADDR[15:0]};
            d.rssi = SAMPLE_RSSI;
            d.flags = 8'h00; // reserved bits zero
            d.flags[iof_pkg::FLAG_ADDR_BCAST_BIT] = SAMPLE_ADDR_BCAST;
            d.flags[iof_pkg::FLAG_PAN_BCAST_BIT] = SAMPLE_PAN_BCAST;
            d.count = SAMPLE_COUNT;
            d.mask = {3'b000, SAMPLE_MASK[12:0]};
            // lines not enabled read as zero
            d.dig = {3'b000, 4'h0, SAMPLE_DIGITAL[8:0] & SAMPLE_MASK[8:0]};
            d.ana = SAMPLE_ANALOG;
            if (q.enable) begin
                d.st = iof_pkg::ST_DELIM;
                d.tx_byte = iof_pkg::DELIM;
                d.tx_valid = 1'b1;
                d.ready = 1'b0;
            end else begin
                d.drops = q.drops + 16'h0001;
            end
        end else if (advance) begin
            // next byte once the last is taken
            d.st = nxt;
            d.addr_idx = nxt_addr_idx;
            d.tx_byte = nxt_byte;
            if (q.st == iof_pkg::ST_MASK_LO || q.st == iof_pkg::ST_DIG_LO) begin
                d.ana_ch = first_ch;
            end else if (q.st == iof_pkg::ST_ANA_LO) begin
                d.ana_ch = nxt_ch;
            end
            if (nxt == iof_pkg::ST_IDLE) begin
                d.tx_valid = 1'b0;
                d.ready = 1'b1;
                d.frames = q.frames + 16'h0001;
            end
        end
        // register writes; only the enable bit is writable
        if (REG_WR && REG_ADDR == iof_pkg::REG_CTRL) begin
            d.enable = REG_WDATA[iof_pkg::CTRL_EN_BIT];
        end
        if (REG_RD) begin
            case (REG_ADDR)
                iof_pkg::REG_CTRL: begin
                    d.rdata[iof_pkg::CTRL_EN_BIT] = q.enable;
                end
                iof_pkg::REG_STATUS: begin
                    d.rdata[iof_pkg::STATUS_BUSY_BIT] = !q.ready;
                    d.rdata[iof_pkg::STATUS_LONG_BIT] = q.is_long;
                end
                iof_pkg::REG_FRAMES: begin
                    d.rdata = {16'h0000, q.frames};
                end
                iof_pkg::REG_DROPS: begin
                    d.rdata = {16'h0000, q.drops};
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            q <= '0;
            q.st <= iof_pkg::ST_IDLE;
            q.ready <= 1'b1;
            q.enable <= iof_pkg::CTRL_EN_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign SAMPLE_READY = q.ready;
    assign TX_DATA = q.tx_byte;
    assign TX_VALID = q.tx_valid;
    assign REG_RDATA = q.rdata;

endmodule

//--- rtl/iof_len.sv
/*
 * Frame data length from mask and address width.
 * Combinational; caller holds inputs for a frame.
 */
`timescale 1ns/10ps
module iof_len (
    input wire logic is_long,        // 64-bit sender address
    input wire logic [15:0] mask,    // channel enable mask
    output logic [15:0] length       // bytes from type to last analog byte
);

    logic [15:0] ana_bytes;

    // ------------------------------------------------------------
    // two bytes per enabled analog channel, two for digital if any
    // ------------------------------------------------------------
    always_comb begin
        ana_bytes = 16'h0000;
        for (int i = 0; i < iof_pkg::ANA_W; i++) begin
            if (mask[iof_pkg::ANA_LSB + i]) begin
                ana_bytes = ana_bytes + 16'h0002;
            end
        end
        length = iof_pkg::LEN_FIXED + ana_bytes
            + (is_long ? iof_pkg::ADDR_LONG_BYTES : iof_pkg::ADDR_SHORT_BYTES)
            + ((|mask[iof_pkg::DIG_LSB +: iof_pkg::DIG_W]) ? 16'h0002 : 16'h0000);
    end

endmodule

//--- rtl/iof_pkg.sv
/*
 * Constants of the frame builder: framing, mask layout,
 * register map and state codes.
 * Assumes one clock domain.
 */
//
// Summary of operation
// - long-address sample goes out as type 0x82
// - short-address sample goes out as type 0x83
// - sender address after type, MSB first
// - signal-strength byte follows address, unsigned magnitude
// - flag byte: bit1 address, bit2 PAN broadcast
// - sample-set count byte follows flags
// - two-byte channel mask, MSB first
// - mask layout: 3 reserved, 4 analog, 9 digital
// - digital word sent when any line enabled
// - no digital line enabled, digital bytes omitted
// - one two-byte field per enabled analog channel
// - analog value 10 bits, upper six zero
// - analog fields in ascending channel order
package iof_pkg;

    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    localparam logic [7:0] DELIM = 8'h7e;
    localparam logic [7:0] TYPE_LONG = 8'h82;
    localparam logic [7:0] TYPE_SHORT = 8'h83;
    localparam logic [7:0] CKSUM_BASE = 8'hff;
    localparam logic [15:0] LEN_FIXED = 16'h0006;  // type, strength, flags, count, mask
    localparam logic [15:0] ADDR_LONG_BYTES = 16'h0008;
    localparam logic [15:0] ADDR_SHORT_BYTES = 16'h0002;
    localparam logic [2:0] ADDR_LONG_TOP = 3'h7;
    localparam logic [2:0] ADDR_SHORT_TOP = 3'h1;

    // ----------------------------------------------------------------
    // channel mask and sample word layout
    // ----------------------------------------------------------------
    localparam int DIG_LSB = 0;
    localparam int DIG_W = 9;
    localparam int ANA_LSB = 9;
    localparam int ANA_W = 4;
    localparam int ANA_BITS = 10;
    localparam int FLAG_ADDR_BCAST_BIT = 1;
    localparam int FLAG_PAN_BCAST_BIT = 2;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FRAMES = 8'h08;
    localparam logic [7:0] REG_DROPS = 8'h0c;
    localparam int CTRL_EN_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LONG_BIT = 1;
    localparam logic CTRL_EN_RESET = 1'b1;

    // ----------------------------------------------------------------
    // builder states, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [15:0] {
        ST_IDLE = 16'h0001,
        ST_DELIM = 16'h0002,
        ST_LEN_HI = 16'h0004,
        ST_LEN_LO = 16'h0008,
        ST_TYPE = 16'h0010,
        ST_ADDR = 16'h0020,
        ST_RSSI = 16'h0040,
        ST_FLAGS = 16'h0080,
        ST_COUNT = 16'h0100,
        ST_MASK_HI = 16'h0200,
        ST_MASK_LO = 16'h0400,
        ST_DIG_HI = 16'h0800,
        ST_DIG_LO = 16'h1000,
        ST_ANA_HI = 16'h2000,
        ST_ANA_LO = 16'h4000,
        ST_CKSUM = 16'h8000
    } iof_state_t;

endpackage

//--- verif/iof_frame_builder_chk.sv
/*
 * Port checker, bound to the frame builder.
 * Assumes the package register map.
 */
`timescale 1ns/10ps
module iof_chk #(
    parameter int NUM_ANA = 4 // analog channels carried
) (
    input wire logic CLOCK,             // system clock
    input wire logic RST_B,             // synchronous reset, active low
    input wire logic SAMPLE_VALID,      // sample set offered
    input wire logic SAMPLE_READY,      // builder idle
    input wire logic SAMPLE_LONG,       // 64-bit sender
    input wire logic [15:0] SAMPLE_MASK, // channel mask
    input wire logic [7:0] TX_DATA,     // frame byte
    input wire logic TX_VALID,          // byte offered
    input wire logic TX_READY,          // byte taken
    input wire logic [7:0] REG_ADDR,    // register address
    input wire logic [31:0] REG_WDATA,  // register write data
    input wire logic REG_WR             // write strobe
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    // ----------------------------------------
    // frame offset tracker
    // ----------------------------------------
    logic [5:0] idx_q, len_w;
    logic [7:0] sum_q;
    logic [15:0] mask_q;
    logic long_q, en_q, take_w, hs_w;
    assign take_w = SAMPLE_VALID && SAMPLE_READY;
    assign hs_w = TX_VALID && TX_READY;
    // length from the latched mask
    assign len_w = 6'd6 + (long_q ? 6'd8 : 6'd2) + ((mask_q[8:0] != 9'h0) ? 6'd2 : 6'd0)
        + 6'd2 * (6'(mask_q[9]) + 6'(mask_q[10]) + 6'(mask_q[11]) + 6'(mask_q[12]));

    // idx_q is the offset of the byte on TX_DATA
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            idx_q <= 6'h00;
            sum_q <= 8'h00;
            mask_q <= 16'h0000;
            long_q <= 1'b0;
            en_q <= iof_pkg::CTRL_EN_RESET;
        end else begin
            if (REG_WR && REG_ADDR == iof_pkg::REG_CTRL)
                en_q <= REG_WDATA[iof_pkg::CTRL_EN_BIT];
            if (SAMPLE_READY)
                idx_q <= 6'h00;
            else if (hs_w)
                idx_q <= idx_q + 6'h01;
            if (take_w) begin
                long_q <= SAMPLE_LONG;
                mask_q <= SAMPLE_MASK;
                sum_q <= 8'h00;
            end else if (hs_w && idx_q >= 6'd3 && idx_q < len_w + 6'd3)
                sum_q <= sum_q + TX_DATA;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_take;
        take_w && en_q;
    endsequence
    sequence s_last;
        hs_w && idx_q == len_w + 6'd3;
    endsequence

    a_start_delim: assert property (s_take |=> !SAMPLE_READY && TX_VALID && TX_DATA == iof_pkg::DELIM)
        else $error("no delimiter first");
    a_len_low: assert property (TX_VALID && idx_q == 6'd2 |-> TX_DATA == {2'b00, len_w})
        else $error("length byte wrong");
    a_type_code: assert property (TX_VALID && idx_q == 6'd3 |->
        TX_DATA == (long_q ? iof_pkg::TYPE_LONG : iof_pkg::TYPE_SHORT))
        else $error("type byte wrong");
    a_flag_reserved: assert property (TX_VALID && idx_q == (long_q ? 6'd13 : 6'd7) |-> (TX_DATA & 8'hf9) == 8'h00)
        else $error("reserved flag bit set");
    a_mask_reserved: assert property (TX_VALID && idx_q == (long_q ? 6'd15 : 6'd9) |-> TX_DATA[7:5] == 3'b000)
        else $error("reserved mask bits set");
    a_cksum_last: assert property (TX_VALID && idx_q == len_w + 6'd3 |-> TX_DATA == 8'hff - sum_q)
        else $error("checksum byte wrong");
    a_frame_end: assert property (s_last |=> SAMPLE_READY && !TX_VALID)
        else $error("no end after checksum");
    a_hold_stall: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("byte changed while stalled");
endmodule

bind iof_frame_builder iof_chk #(.NUM_ANA(NUM_ANA)) chk_u (.CLOCK(CLOCK), .RST_B(RST_B),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY), .SAMPLE_LONG(SAMPLE_LONG),
    .SAMPLE_MASK(SAMPLE_MASK), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR));

//--- verif/iof_host_model.sv
/*
 * Host model: keeps frame bytes in arrival order.
 * Assumes the builder's clock; no UART bit timing.
 */
`timescale 1ns/10ps
module iof_host_model (
    input wire logic clk,           // system clock
    input wire logic rst_b,         // synchronous reset, active low
    input wire logic slow,          // host stalls now and then
    input wire logic tx_valid,      // byte offered
    input wire logic [7:0] tx_data, // frame byte
    output logic tx_ready           // host takes the byte
);
    logic [7:0] rx_q[$];
    integer seed = 32'h5a17;

    // slow host stalls about half the edges
    always @(posedge clk) begin
        tx_ready <= rst_b && (!slow || (($random(seed) & 1) == 0));
        if (rst_b && tx_valid && tx_ready)
            rx_q.push_back(tx_data);
    end
endmodule

//--- verif/tb_top.sv
/*
 * Bench for the frame builder, host model on the UART side.
 * Assumes the package register map.
 */
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic smp_valid = 1'b0, smp_long = 1'b0, smp_ab = 1'b0, smp_pb = 1'b0;
    logic [63:0] smp_addr = 64'h0;
    logic [7:0] smp_rssi = 8'h00, smp_cnt = 8'h00, reg_addr = 8'h00;
    logic [15:0] smp_mask = 16'h0000, smp_dig = 16'h0000;
    logic [39:0] smp_ana = 40'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic smp_ready, tx_valid, tx_ready;
    logic [7:0] tx_data;
    logic [7:0] exp_q[$];
    logic [15:0] corner_q[6] = '{16'h0000, 16'h1e00, 16'h01ff, 16'hffff, 16'h0201, 16'h0100};
    int n_errors = 0, checked = 0, frames = 0;
    integer seed = 32'hcec7;

    always #2.5 clk = ~clk;

    iof_frame_builder dut_u (.CLOCK(clk), .RST_B(rst_b), .SAMPLE_VALID(smp_valid), .SAMPLE_READY(smp_ready),
        .SAMPLE_LONG(smp_long), .SAMPLE_ADDR(smp_addr), .SAMPLE_RSSI(smp_rssi), .SAMPLE_ADDR_BCAST(smp_ab),
        .SAMPLE_PAN_BCAST(smp_pb), .SAMPLE_COUNT(smp_cnt), .SAMPLE_MASK(smp_mask), .SAMPLE_DIGITAL(smp_dig),
        .SAMPLE_ANALOG(smp_ana), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    iof_host_model host_u (.clk(clk), .rst_b(rst_b), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready));

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_word({24'h0, got}, {24'h0, exp});
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // idle edge between calls
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        cmp_word(reg_rdata, exp);
    endtask

    // expected frame from the inputs
    function automatic void exp_frame(input logic [15:0] m, input logic lg);
        logic [7:0] sum;
        exp_q = {lg ? iof_pkg::TYPE_LONG : iof_pkg::TYPE_SHORT};
        for (int k = lg ? 7 : 1; k >= 0; k--)
            exp_q.push_back(smp_addr[8*k +: 8]);
        exp_q.push_back(smp_rssi);
        exp_q.push_back({5'h0, smp_pb, smp_ab, 1'b0});
        exp_q.push_back(smp_cnt);
        exp_q.push_back({3'h0, m[12:8]});
        exp_q.push_back(m[7:0]);
        if (m[8:0] != 9'h0) begin
            exp_q.push_back({7'h0, smp_dig[8] & m[8]});
            exp_q.push_back(smp_dig[7:0] & m[7:0]);
        end
        for (int k = 0; k < 4; k++)
            if (m[9+k]) begin
                exp_q.push_back({6'h0, smp_ana[10*k+8 +: 2]});
                exp_q.push_back(smp_ana[10*k +: 8]);
            end
        sum = 8'h00;
        foreach (exp_q[i])
            sum += exp_q[i];
        exp_q.push_back(8'hff - sum);
        exp_q.push_front(8'(exp_q.size() - 1));
        exp_q.push_front(8'h00);
        exp_q.push_front(iof_pkg::DELIM);
    endfunction

    // offer a random set, check the frame the host saw
    task automatic send_set(input logic [15:0] m, input logic lg, input logic en);
        int k = 0;
        smp_long <= lg;
        smp_mask <= m;
        smp_addr <= {$random(seed), $random(seed)};
        {smp_rssi, smp_cnt, smp_ab, smp_pb} <= 18'($random(seed));
        smp_dig <= 16'($random(seed));
        smp_ana <= {8'($random(seed)), $random(seed)};
        smp_valid <= 1'b1;
        @(posedge clk);
        smp_valid <= 1'b0;
        exp_frame(m, lg);
        do begin
            @(posedge clk);
            k++;
        end while (smp_ready !== 1'b1 && k < 2000);
        frames += en;
        cmp_byte(8'(host_u.rx_q.size()), en ? 8'(exp_q.size()) : 8'h00);
        if (en)
            foreach (exp_q[i])
                cmp_byte(host_u.rx_q[i], exp_q[i]);
        host_u.rx_q.delete();
    endtask

    task automatic stop_test();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        reg_read(iof_pkg::REG_CTRL, 32'h1);
        reg_read(iof_pkg::REG_STATUS, 32'h0);
        reg_read(iof_pkg::REG_FRAMES, 32'h0);
        reg_read(8'h10, 32'h0);
        $display("test reset done");
        // every corner mask in both widths, slow host on odd-indexed masks only
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            send_set(corner_q[i % 6], 1'(i / 6), 1'b1);
        end
        $display("test corner masks done");
        repeat (24) begin
            slow <= 1'($random(seed));
            send_set(16'($random(seed)), 1'($random(seed)), 1'b1);
        end
        $display("test random frames done");
        // disabled: set dropped and counted
        reg_write(iof_pkg::REG_CTRL, 32'h0);
        send_set(16'h1fff, 1'b0, 1'b0);
        reg_read(iof_pkg::REG_DROPS, 32'h1);
        reg_write(iof_pkg::REG_CTRL, 32'h1);
        send_set(16'h0e01, 1'b1, 1'b1);
        reg_read(iof_pkg::REG_FRAMES, 32'(frames));
        reg_read(iof_pkg::REG_STATUS, 32'h2);
        $display("test enable done");
        stop_test();
    end

    // ample span for the whole run
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule
